// *** bench/plsm_drive_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module plsm_drive_model (
    input wire logic         clock, set_lim,
    input wire logic [15:0]  set_freq, set_gap, set_torq, set_cur,
    output logic [15:0]      ref_f, mot_f, torq, cur,
    output logic             lim
);
    // Estimates start idle, then refresh once per control cycle
    initial {ref_f, mot_f, torq, cur, lim} = '0;
    always @(posedge clock) begin
        ref_f <= set_freq + set_gap;
        {mot_f, torq, cur, lim} <= {set_freq, set_torq, set_cur, set_lim};
    end
endmodule
`default_nettype wire

// *** bench/plsm_monitor_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module plsm_monitor_chk
    import plsm_pkg::*;
(
    input wire logic             CLOCK, NRST, WR, RD, IRQ, RESTART_OK,
    input wire logic             UNDERLOAD_ERROR, OVERLOAD_ERROR, STALL_ERROR,
    input wire logic [7:0]       ADDR,
    input wire logic [31:0]      WDATA, RDATA,
    input wire plsm_pkg::plsm_react_t STOP_REQ
);
    // ----------------------------------------
    // Bus, latching and reaction checks
    // ----------------------------------------
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!NRST);
    wire logic any_err = UNDERLOAD_ERROR | OVERLOAD_ERROR | STALL_ERROR;  // Any latched error pin
    rdata_idle_a: assert property (!$past(RD) |-> RDATA == 32'h0) else $error("read data outside slot");
    ul_latch_a: assert property ($fell(UNDERLOAD_ERROR) |-> $past(WR, 2) && $past(ADDR, 2) == OFS_STATUS
        && $past(WDATA[0], 2)) else $error("underload flag dropped without clear");
    ol_latch_a: assert property ($fell(OVERLOAD_ERROR) |-> $past(WR, 2) && $past(ADDR, 2) == OFS_STATUS
        && $past(WDATA[1], 2)) else $error("overload flag dropped without clear");
    st_latch_a: assert property ($fell(STALL_ERROR) |-> $past(WR, 2) && $past(ADDR, 2) == OFS_STATUS
        && $past(WDATA[2], 2)) else $error("stall flag dropped without clear");
    irq_cause_a: assert property (IRQ |=> any_err) else $error("interrupt without error");
    reset_vals_a: assert property ($rose(NRST) |-> RESTART_OK && !IRQ && !any_err
        && STOP_REQ == PLSM_IGNORE) else $error("outputs wrong after reset");
    stall_block_a: assert property (STALL_ERROR |-> !RESTART_OK) else $error("restart allowed on stall");
    stop_cause_a: assert property (STOP_REQ != PLSM_IGNORE |-> ##[0:1] any_err)
        else $error("stop request without error");
endmodule
bind plsm_monitor plsm_monitor_chk plsm_monitor_chk_inst (.CLOCK, .NRST, .WR, .RD, .IRQ, .RESTART_OK,
    .UNDERLOAD_ERROR, .OVERLOAD_ERROR, .STALL_ERROR, .ADDR, .WDATA, .RDATA, .STOP_REQ);
`default_nettype wire

// *** bench/test_plsm_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module test_plsm_monitor;
    import plsm_pkg::*;
    logic        CLOCK = 0, NRST = 0, WR = 0, RD = 0, lim = 0, rd_d = 0, lim_w, ule, ole, ste, rok, irq;
    logic [7:0]  ADDR = 8'h0;
    logic [31:0] WDATA = 32'h0, RDATA, v, exp_v, exp_q[$];
    logic [15:0] fq = 16'h0, tq = 16'h0, cu = 16'h0, gap = 16'h0, ref_w, frq_w, trq_w, cur_w;
    plsm_react_t stop;
    int          err_count = 0, checks_done = 0, cyc = 0, seed = 39664, i;
    logic [7:0]  ra[7] = '{8'h00, 8'h08, 8'h14, 8'h20, 8'h28, 8'h2c, 8'h48};   // Reset table, last unmapped
    logic [31:0] rv[7] = '{32'h14, 32'h258, 32'h3, 32'h44c, 32'h258, 32'h5dc, 32'h0};
    plsm_monitor #(.TICK_LEN(10)) plsm_monitor_inst (.CLOCK, .NRST, .ADDR, .WDATA, .WR, .RD, .RDATA,
        .PRE_RAMP_REFERENCE(ref_w), .MOTOR_FREQUENCY(frq_w), .MOTOR_TORQUE(trq_w), .MOTOR_CURRENT(cur_w),
        .CURRENT_LIMITING_STATE(lim_w), .UNDERLOAD_ERROR(ule), .OVERLOAD_ERROR(ole), .STALL_ERROR(ste),
        .STOP_REQ(stop), .RESTART_OK(rok), .IRQ(irq));
    plsm_drive_model plsm_drive_model_inst (.clock(CLOCK), .set_lim(lim), .set_freq(fq), .set_gap(gap),
        .set_torq(tq), .set_cur(cu), .ref_f(ref_w), .mot_f(frq_w), .torq(trq_w), .cur(cur_w), .lim(lim_w));
    initial forever #25 CLOCK = ~CLOCK;
    // ----------------------------------------
    // Bus tasks and closing report
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLOCK) {WR, ADDR, WDATA} <= {1'b1, a, d};
        @(posedge CLOCK) WR <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge CLOCK) {RD, ADDR} <= {1'b1, a};
        exp_q.push_back(e);
        @(posedge CLOCK) RD <= 1'b0;
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Read data compared one cycle after each read; cycle ceiling guards hangs
    always @(posedge CLOCK) begin
        cyc++;
        if (rd_d) begin
            exp_v = exp_q.pop_front();
            `CHK(RDATA, exp_v)
        end
        rd_d <= RD;
        if (cyc > 3000) begin err_count++; report_and_stop(); end
    end
    initial begin
        repeat (20) @(posedge CLOCK);
        NRST <= 1'b1;
        for (i = 0; i < 7; i++) rd(ra[i], rv[i]);
        v = $unsigned($random(seed)) % 2001;
        wr(8'h28, v);
        rd(8'h28, v);
        $display("reset values and readback done");
        {fq, cu, gap} <= {16'd10, 16'd1600, 16'd100};   // Slow, overcurrent, not steady
        wr(8'h28, 32'h2);
        wr(8'h00, 32'h15);
        repeat (15) @(posedge CLOCK);
        rd(8'h3c, 32'h0);
        repeat (30) @(posedge CLOCK);
        rd(8'h3c, 32'h4);
        `CHK(ste, 1'b1)
        `CHK(stop, PLSM_FREEWHEEL)
        `CHK(rok, 1'b0)
        cu <= 16'd0;
        wr(8'h3c, 32'h4);
        rd(8'h3c, 32'h0);
        `CHK(ste, 1'b0)
        $display("stall done");
        lim <= 1'b1;                                    // Current limiting while not steady
        wr(8'h40, 32'h2);
        wr(8'h1c, 32'h1);
        repeat (80) @(posedge CLOCK);
        rd(8'h3c, 32'h0);
        repeat (40) @(posedge CLOCK);
        rd(8'h3c, 32'h2);
        `CHK(ole, 1'b1)
        `CHK(rok, 1'b0)
        `CHK(stop, PLSM_FREEWHEEL)
        `CHK(irq, 1'b1)
        wr(8'h40, 32'h0);
        repeat (2) @(posedge CLOCK);
        `CHK(irq, 1'b0)
        lim <= 1'b0;
        wr(8'h3c, 32'h2);
        wr(8'h1c, 32'h0);
        $display("overload done");
        {fq, gap, tq} <= {16'd500, 16'd0, 16'd50};      // Steady at rated speed, light torque
        wr(8'h10, 32'd501);
        wr(8'h04, 32'h1);
        repeat (120) @(posedge CLOCK);
        rd(8'h3c, 32'h0);
        wr(8'h10, 32'h0);
        repeat (120) @(posedge CLOCK);
        rd(8'h3c, 32'h1);
        `CHK(ule, 1'b1)
        `CHK(stop, PLSM_FREEWHEEL)
        `CHK(rok, 1'b0)
        wr(8'h34, 32'h1);
        repeat (2) @(posedge CLOCK);
        `CHK(rok, 1'b1)
        $display("underload done");
        repeat (3) @(posedge CLOCK);
        report_and_stop();
    end
endmodule
`default_nettype wire

// *** logic/plsm_monitor.sv ***
// Overview of operation
// - Underload when steady, torque low, for delay
// - Steady when frequency gap below hysteresis
// - Underload limit follows quadratic frequency curve
// - No underload detection below minimum frequency
// - Underload timer clears above zero-threshold plus 10%
// - Zero delay disables underload or overload
// - Underload thresholds default 60% and 0%
// - Underload reaction selectable, freewheel default
// - Underload blocks restart for holdoff; fault reset time must be a minute longer
// - Overload on current limit or steady overcurrent
// - Current limitation arms overload monitoring, unless overload delay is zero
// - Overload threshold percent of rated, default 110%
// - Overload reaction selectable, freewheel default
// - Overload blocks restart for holdoff; fault reset time must be a minute longer
// - Stall when slow and overcurrent too long
// - Stall time default 60.0 s
// - Stall current default 150.0 %
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module plsm_monitor
#(
    parameter int TICK_LEN = plsm_pkg::TICK_CYCLES     // Cycles per 0.1 s tick
) (
    input  wire logic        CLOCK,
    input  wire logic        NRST,
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA,
    input  wire logic [15:0] PRE_RAMP_REFERENCE,
    input  wire logic [15:0] MOTOR_FREQUENCY,
    input  wire logic [15:0] MOTOR_TORQUE,
    input  wire logic [15:0] MOTOR_CURRENT,
    input  wire logic        CURRENT_LIMITING_STATE,
    output logic             UNDERLOAD_ERROR,
    output logic             OVERLOAD_ERROR,
    output logic             STALL_ERROR,
    output plsm_pkg::plsm_react_t STOP_REQ,
    output logic             RESTART_OK,
    output logic             IRQ
);
    import plsm_pkg::*;
    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    logic [5:0]  ctrl_ff;               // Enable and reaction fields
    logic [15:0] ul_delay_ff;           // Underload delay, s
    logic [15:0] ul_nom_ff;             // Threshold at rated speed
    logic [15:0] ul_zero_ff;            // Threshold at zero speed
    logic [15:0] ul_minf_ff;            // Minimum frequency
    logic [15:0] hyst_ff;               // Steady state hysteresis
    logic [15:0] ul_hold_ff;            // Underload holdoff, min
    logic [15:0] ol_delay_ff;           // Overload delay, s
    logic [15:0] ol_thr_ff;             // Overload threshold
    logic [15:0] ol_hold_ff;            // Overload holdoff, min
    logic [15:0] st_time_ff;            // Stall time, 0.1 s
    logic [15:0] st_cur_ff;             // Stall current
    logic [15:0] st_freq_ff;            // Stall frequency
    logic [15:0] frst_time_ff;          // Fault reset time, min
    logic [15:0] rated_freq_ff;         // Rated frequency
    logic [2:0]  status_ff;             // Latched errors
    logic [2:0]  mask_ff;               // Interrupt mask
    logic [31:0] nxt_rdata;             // Read mux result
    logic [31:0] tick_cnt_ff;           // Time base divider
    logic        tick;                  // One pulse per 0.1 s
    logic [15:0] freq_gap;              // Absolute gap between reference and motor frequency
    logic        steady;                // Motor in steady state
    logic [15:0] f_clamped;             // Frequency clipped to rated
    logic [15:0] thr_span;              // Nominal minus zero threshold
    logic [49:0] ul_lhs;                // Torque times rated squared
    logic [49:0] ul_rhs;                // Limit times rated squared
    logic [15:0] ul_release;            // Zero threshold plus margin
    logic [2:0]  cond;                  // Live condition per channel
    logic [2:0]  chan_en;               // Channel enabled
    logic [2:0]  chan_clr;              // Channel timer forced clear
    logic [15:0] limit [3];             // Delay limit in ticks
    logic [15:0] dly_cnt_ff [3];        // Delay counters
    logic [2:0]  detect;                // Delay elapsed with condition
    logic [2:0]  detect_q_ff;           // Detect, one cycle late
    logic [2:0]  det_rise;              // New detection pulse
    logic [2:0]  w1c;                   // Status clear by software
    logic [15:0] hold_cnt_ff [2];       // Holdoff counters, ticks
    logic [15:0] hold_lim [2];          // Holdoff limits, ticks
    logic [15:0] hold_min [2];          // Holdoff settings, min
    logic [1:0]  hold_ok;               // Restart permitted per error
    plsm_react_t nxt_stop;              // Merged stop reaction
    logic        nxt_restart;           // Restart permission

    // ---------------------------------------------------------------
    // Helper functions
    // ---------------------------------------------------------------
    // Register write hit at a given offset
    function automatic logic wr_hit(input logic [7:0] ofs);
        wr_hit = WR && (ADDR == ofs);
    endfunction

    // Stronger of two stop reactions: freewheel, fast, ramp, ignore
    function automatic plsm_react_t merge(input plsm_react_t a, input plsm_react_t b);
        logic [1:0] ra;
        logic [1:0] rb;
        ra = (a == PLSM_FREEWHEEL) ? 2'h3 : (a == PLSM_FAST) ? 2'h2 : (a == PLSM_RAMP) ? 2'h1 : 2'h0;
        rb = (b == PLSM_FREEWHEEL) ? 2'h3 : (b == PLSM_FAST) ? 2'h2 : (b == PLSM_RAMP) ? 2'h1 : 2'h0;
        merge = (ra >= rb) ? a : b;
    endfunction

    // ---------------------------------------------------------------
    // Configuration registers
    // ---------------------------------------------------------------
    // Control: stall enable and both reactions, freewheel by default
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            ctrl_ff <= {PLSM_FREEWHEEL, PLSM_FREEWHEEL, 1'b0, 1'b0};
        end else if (wr_hit(OFS_CTRL)) begin
            ctrl_ff <= WDATA[5:0];
        end
    end

    // Underload settings
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            ul_delay_ff <= RST_UL_DELAY;
            ul_nom_ff   <= RST_UL_NOM;
            ul_zero_ff  <= RST_UL_ZERO;
            ul_minf_ff  <= RST_UL_MINF;
            hyst_ff     <= RST_HYST;
            ul_hold_ff  <= RST_HOLD;
        end else begin
            if (wr_hit(OFS_UL_DELAY)) ul_delay_ff <= WDATA[15:0];
            if (wr_hit(OFS_UL_NOM))   ul_nom_ff   <= WDATA[15:0];
            if (wr_hit(OFS_UL_ZERO))  ul_zero_ff  <= WDATA[15:0];
            if (wr_hit(OFS_UL_MINF))  ul_minf_ff  <= WDATA[15:0];
            if (wr_hit(OFS_HYST))     hyst_ff     <= WDATA[15:0];
            if (wr_hit(OFS_UL_HOLD))  ul_hold_ff  <= WDATA[15:0];
        end
    end

    // Overload, stall and shared settings
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            ol_delay_ff   <= RST_OL_DELAY;
            ol_thr_ff     <= RST_OL_THR;
            ol_hold_ff    <= RST_HOLD;
            st_time_ff    <= RST_ST_TIME;
            st_cur_ff     <= RST_ST_CUR;
            st_freq_ff    <= RST_ST_FREQ;
            frst_time_ff  <= RST_FRST_TIME;
            rated_freq_ff <= RST_RATED_FREQ;
        end else begin
            if (wr_hit(OFS_OL_DELAY))   ol_delay_ff   <= WDATA[15:0];
            if (wr_hit(OFS_OL_THR))     ol_thr_ff     <= WDATA[15:0];
            if (wr_hit(OFS_OL_HOLD))    ol_hold_ff    <= WDATA[15:0];
            if (wr_hit(OFS_ST_TIME))    st_time_ff    <= WDATA[15:0];
            if (wr_hit(OFS_ST_CUR))     st_cur_ff     <= WDATA[15:0];
            if (wr_hit(OFS_ST_FREQ))    st_freq_ff    <= WDATA[15:0];
            if (wr_hit(OFS_FRST_TIME))  frst_time_ff  <= WDATA[15:0];
            if (wr_hit(OFS_RATED_FREQ)) rated_freq_ff <= WDATA[15:0];
        end
    end

    // Interrupt mask
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            mask_ff <= 3'h0;
        end else if (wr_hit(OFS_MASK)) begin
            mask_ff <= WDATA[2:0];
        end
    end

    // ---------------------------------------------------------------
    // Time base
    // ---------------------------------------------------------------
    // Divider producing one tick every 0.1 s
    always_ff @(posedge CLOCK) begin
        if (!NRST || tick) begin
            tick_cnt_ff <= 32'h0;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 32'h1;
        end
    end
    assign tick = (tick_cnt_ff == 32'(TICK_LEN - 1));

    // ---------------------------------------------------------------
    // Condition evaluation
    // ---------------------------------------------------------------
    // Absolute gap between reference and motor frequency
    assign freq_gap = (PRE_RAMP_REFERENCE >= MOTOR_FREQUENCY) ? (PRE_RAMP_REFERENCE - MOTOR_FREQUENCY)
                                                              : (MOTOR_FREQUENCY - PRE_RAMP_REFERENCE);
    assign steady = (freq_gap < hyst_ff);

    // Quadratic limit without division: torque*fr^2 < zero*fr^2 + span*f^2
    assign f_clamped = (MOTOR_FREQUENCY > rated_freq_ff) ? rated_freq_ff : MOTOR_FREQUENCY;
    assign thr_span  = (ul_nom_ff > ul_zero_ff) ? (ul_nom_ff - ul_zero_ff) : 16'h0;
    assign ul_lhs    = 50'(MOTOR_TORQUE * (rated_freq_ff * rated_freq_ff));
    assign ul_rhs    = 50'(ul_zero_ff * (rated_freq_ff * rated_freq_ff)) + 50'(thr_span * (f_clamped * f_clamped));
    assign ul_release = ul_zero_ff + 16'(HYST_MARGIN);

    // Live conditions, enables and clears per channel
    always_comb begin
        cond[ST_UNDERLOAD] = steady && (ul_lhs < ul_rhs)
                             && (MOTOR_FREQUENCY >= ul_minf_ff);
        cond[ST_OVERLOAD]  = CURRENT_LIMITING_STATE
                             || (steady && (MOTOR_CURRENT > ol_thr_ff));
        cond[ST_STALL]     = (MOTOR_FREQUENCY < st_freq_ff) && (MOTOR_CURRENT > st_cur_ff);
        chan_en[ST_UNDERLOAD] = (ul_delay_ff != 16'h0);
        chan_en[ST_OVERLOAD]  = (ol_delay_ff != 16'h0);
        chan_en[ST_STALL]     = ctrl_ff[CTRL_STALL_EN];
        chan_clr[ST_UNDERLOAD] = (MOTOR_TORQUE > ul_release);
        chan_clr[ST_OVERLOAD]  = 1'b0;
        chan_clr[ST_STALL]     = 1'b0;
        limit[ST_UNDERLOAD] = 16'(ul_delay_ff * 16'(TICKS_PER_SEC));
        limit[ST_OVERLOAD]  = 16'(ol_delay_ff * 16'(TICKS_PER_SEC));
        limit[ST_STALL]     = st_time_ff + 16'h1;
    end

    // ---------------------------------------------------------------
    // Delay timers
    // ---------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_delay
            // Counts ticks while the condition persists, saturates at limit
            always_ff @(posedge CLOCK) begin
                if (!NRST || !chan_en[gi] || chan_clr[gi] || !cond[gi]) begin
                    dly_cnt_ff[gi] <= 16'h0;
                end else if (tick && (dly_cnt_ff[gi] < limit[gi])) begin
                    dly_cnt_ff[gi] <= dly_cnt_ff[gi] + 16'h1;
                end
            end
            assign detect[gi] = chan_en[gi] && cond[gi] && !chan_clr[gi]
                                && (dly_cnt_ff[gi] >= limit[gi]);
        end
    endgenerate

    // Edge of detection, for status setting and holdoff start
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            detect_q_ff <= 3'h0;
        end else begin
            detect_q_ff <= detect;
        end
    end
    assign det_rise = detect & ~detect_q_ff;

    // ---------------------------------------------------------------
    // Latched errors and interrupt
    // ---------------------------------------------------------------
    assign w1c = wr_hit(OFS_STATUS) ? WDATA[2:0] : 3'h0;

    // Sticky errors; a new detection wins over a clear
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            status_ff <= 3'h0;
        end else begin
            status_ff <= (status_ff & ~w1c) | det_rise;
        end
    end

    // Interrupt level from unmasked errors
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(((status_ff & ~w1c) | det_rise) & mask_ff);
        end
    end

    // ---------------------------------------------------------------
    // Restart holdoff
    // ---------------------------------------------------------------
    assign hold_min[0] = ul_hold_ff;
    assign hold_min[1] = ol_hold_ff;

    generate
        for (gi = 0; gi < 2; gi++) begin : g_hold
            assign hold_lim[gi] = 16'(hold_min[gi] * 16'(TICKS_PER_MIN));
            // Restarts on each detection, saturates at the holdoff
            always_ff @(posedge CLOCK) begin
                if (!NRST || det_rise[gi]) begin
                    hold_cnt_ff[gi] <= 16'h0;
                end else if (tick && (hold_cnt_ff[gi] < hold_lim[gi])) begin
                    hold_cnt_ff[gi] <= hold_cnt_ff[gi] + 16'h1;
                end
            end
            // Holdoff elapsed and fault reset time a minute longer
            assign hold_ok[gi] = !status_ff[gi] || ((hold_cnt_ff[gi] >= hold_lim[gi])
                                 && (frst_time_ff >= hold_min[gi] + 16'h1));
        end
    endgenerate

    // ---------------------------------------------------------------
    // Reactions and outputs
    // ---------------------------------------------------------------
    // Strongest reaction among latched errors
    always_comb begin
        nxt_stop = PLSM_IGNORE;
        if (status_ff[ST_UNDERLOAD]) begin
            nxt_stop = merge(nxt_stop, plsm_react_t'(ctrl_ff[CTRL_UL_REACT +: 2]));
        end
        if (status_ff[ST_OVERLOAD]) begin
            nxt_stop = merge(nxt_stop, plsm_react_t'(ctrl_ff[CTRL_OL_REACT +: 2]));
        end
        if (status_ff[ST_STALL]) begin
            nxt_stop = merge(nxt_stop, PLSM_FREEWHEEL);
        end
        nxt_restart = &hold_ok && !status_ff[ST_STALL];
    end

    // Registered error, stop and restart outputs
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            UNDERLOAD_ERROR <= 1'b0;
            OVERLOAD_ERROR  <= 1'b0;
            STALL_ERROR     <= 1'b0;
            STOP_REQ        <= PLSM_IGNORE;
            RESTART_OK      <= 1'b1;
        end else begin
            UNDERLOAD_ERROR <= status_ff[ST_UNDERLOAD];
            OVERLOAD_ERROR  <= status_ff[ST_OVERLOAD];
            STALL_ERROR     <= status_ff[ST_STALL];
            STOP_REQ        <= nxt_stop;
            RESTART_OK      <= nxt_restart;
        end
    end

    // ---------------------------------------------------------------
    // Register read port
    // ---------------------------------------------------------------
    // Read mux; unmapped offsets read zero
    always_comb begin
        case (ADDR)
            OFS_CTRL:       nxt_rdata = {26'h0, ctrl_ff};
            OFS_UL_DELAY:   nxt_rdata = {16'h0, ul_delay_ff};
            OFS_UL_NOM:     nxt_rdata = {16'h0, ul_nom_ff};
            OFS_UL_ZERO:    nxt_rdata = {16'h0, ul_zero_ff};
            OFS_UL_MINF:    nxt_rdata = {16'h0, ul_minf_ff};
            OFS_HYST:       nxt_rdata = {16'h0, hyst_ff};
            OFS_UL_HOLD:    nxt_rdata = {16'h0, ul_hold_ff};
            OFS_OL_DELAY:   nxt_rdata = {16'h0, ol_delay_ff};
            OFS_OL_THR:     nxt_rdata = {16'h0, ol_thr_ff};
            OFS_OL_HOLD:    nxt_rdata = {16'h0, ol_hold_ff};
            OFS_ST_TIME:    nxt_rdata = {16'h0, st_time_ff};
            OFS_ST_CUR:     nxt_rdata = {16'h0, st_cur_ff};
            OFS_ST_FREQ:    nxt_rdata = {16'h0, st_freq_ff};
            OFS_FRST_TIME:  nxt_rdata = {16'h0, frst_time_ff};
            OFS_RATED_FREQ: nxt_rdata = {16'h0, rated_freq_ff};
            OFS_STATUS:     nxt_rdata = {29'h0, status_ff};
            OFS_MASK:       nxt_rdata = {29'h0, mask_ff};
            OFS_MON:        nxt_rdata = {27'h0, nxt_restart, steady, cond};
            default:        nxt_rdata = 32'h0;
        endcase
    end

    // Read data valid in the cycle after the strobe only
    always_ff @(posedge CLOCK) begin
        if (!NRST || !RD) begin
            RDATA <= 32'h0;
        end else begin
            RDATA <= nxt_rdata;
        end
    end

endmodule

`default_nettype wire

// *** logic/plsm_pkg.sv ***
package plsm_pkg;

    // ---------------------------------------------------------------
    // Clock and time base
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 50;                             // 20 MHz system clock
    localparam int TICK_TIME_NS   = 100_000_000;                    // 0.1 s time base
    localparam int TICK_CYCLES    = TICK_TIME_NS / CLK_PERIOD_NS;   // Cycles per tick
    localparam int TICKS_PER_SEC  = 10;                             // Ticks in one second
    localparam int TICKS_PER_MIN  = 600;                            // Ticks in one minute
    localparam int HYST_MARGIN    = 100;                            // 10 % of rated, in 0.1 %

    // ---------------------------------------------------------------
    // Register byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL       = 8'h00;  // Enable and reactions
    localparam logic [7:0] OFS_UL_DELAY   = 8'h04;  // Underload delay, s
    localparam logic [7:0] OFS_UL_NOM     = 8'h08;  // Underload thr nominal, 0.1 %
    localparam logic [7:0] OFS_UL_ZERO    = 8'h0c;  // Underload thr zero speed, 0.1 %
    localparam logic [7:0] OFS_UL_MINF    = 8'h10;  // Underload min freq, 0.1 Hz
    localparam logic [7:0] OFS_HYST       = 8'h14;  // Steady state hysteresis, 0.1 Hz
    localparam logic [7:0] OFS_UL_HOLD    = 8'h18;  // Underload restart holdoff, min
    localparam logic [7:0] OFS_OL_DELAY   = 8'h1c;  // Overload delay, s
    localparam logic [7:0] OFS_OL_THR     = 8'h20;  // Overload threshold, 0.1 %
    localparam logic [7:0] OFS_OL_HOLD    = 8'h24;  // Overload restart holdoff, min
    localparam logic [7:0] OFS_ST_TIME    = 8'h28;  // Stall time, 0.1 s
    localparam logic [7:0] OFS_ST_CUR     = 8'h2c;  // Stall current, 0.1 %
    localparam logic [7:0] OFS_ST_FREQ    = 8'h30;  // Stall frequency, 0.1 Hz
    localparam logic [7:0] OFS_FRST_TIME  = 8'h34;  // Fault reset time, min
    localparam logic [7:0] OFS_RATED_FREQ = 8'h38;  // Rated motor frequency, 0.1 Hz
    localparam logic [7:0] OFS_STATUS     = 8'h3c;  // Latched errors, write one to clear
    localparam logic [7:0] OFS_MASK       = 8'h40;  // Interrupt mask
    localparam logic [7:0] OFS_MON        = 8'h44;  // Live condition monitor

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int CTRL_STALL_EN  = 0;   // Stall monitoring enable
    localparam int CTRL_UL_REACT  = 2;   // Underload reaction, 2 bits
    localparam int CTRL_OL_REACT  = 4;   // Overload reaction, 2 bits
    localparam int ST_UNDERLOAD   = 0;   // Status bit positions
    localparam int ST_OVERLOAD    = 1;
    localparam int ST_STALL       = 2;
    localparam int MON_STEADY     = 3;   // Monitor: steady state
    localparam int MON_RESTART_OK = 4;   // Monitor: restart allowed

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [15:0] RST_UL_DELAY   = 16'h0000;  // 0 s
    localparam logic [15:0] RST_UL_NOM     = 16'h0258;  // 60.0 %
    localparam logic [15:0] RST_UL_ZERO    = 16'h0000;  // 0.0 %
    localparam logic [15:0] RST_UL_MINF    = 16'h0000;  // 0.0 Hz
    localparam logic [15:0] RST_HYST       = 16'h0003;  // 0.3 Hz
    localparam logic [15:0] RST_HOLD       = 16'h0000;  // 0 min
    localparam logic [15:0] RST_OL_DELAY   = 16'h0000;  // 0 s
    localparam logic [15:0] RST_OL_THR     = 16'h044c;  // 110.0 %
    localparam logic [15:0] RST_ST_TIME    = 16'h0258;  // 60.0 s
    localparam logic [15:0] RST_ST_CUR     = 16'h05dc;  // 150.0 %
    localparam logic [15:0] RST_ST_FREQ    = 16'h0014;  // 2.0 Hz
    localparam logic [15:0] RST_FRST_TIME  = 16'h0000;  // 0 min
    localparam logic [15:0] RST_RATED_FREQ = 16'h01f4;  // 50.0 Hz

    // ---------------------------------------------------------------
    // Stop reactions
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        PLSM_IGNORE    = 2'b00,   // Error ignored
        PLSM_FREEWHEEL = 2'b01,   // Freewheel stop
        PLSM_RAMP      = 2'b10,   // Stop on ramp
        PLSM_FAST      = 2'b11    // Fast stop
    } plsm_react_t;

endpackage
